/* File: meter_config_regs.svh */
// register offsets, reset values and code points of the meter settings bank
// assumes a 16-bit register number from the serial frame decoder
`ifndef METER_CONFIG_REGS_SVH
`define METER_CONFIG_REGS_SVH
`define OFS_STATION 8'h20
`define OFS_BAUD 8'h22
`define OFS_PERMIT 8'h23
`define OFS_LOCKOUT 8'h24
`define OFS_REPLY_WAIT 8'h25
`define OFS_GAP 8'h27
`define OFS_GLOW 8'h2d
`define OFS_TINT 8'h2e
`define OFS_EDIT 8'h2f
`define OFS_O1_THR 8'h30
`define OFS_O1_BAND 8'h31
`define OFS_O1_MODE 8'h32
`define OFS_O1_ON 8'h33
`define OFS_O1_OFF 8'h34
`define OFS_O1_UNIT 8'h35
`define OFS_O1_FAULT 8'h36
`define OFS_O1_THR2 8'h37
`define OFS_O2_THR 8'h38
`define OFS_O2_BAND 8'h39
`define OFS_O2_MODE 8'h3a
`define OFS_O2_ON 8'h3b
`define OFS_O2_OFF 8'h3c
`define OFS_O2_UNIT 8'h3d
`define OFS_O2_FAULT 8'h3e
`define OFS_O2_THR2 8'h3f
`define OFS_CAPTURE 8'h50
`define OFS_MIN_EXC 8'h51
`define OFS_SHOW 8'h52
`define OFS_DISP_FRZ 8'h53
`define OFS_O1_FRZ 8'h54
`define OFS_O2_FRZ 8'h55
`define OFS_TINT_FLAGS 8'h60
`define OFS_TINT_CLR 8'h61
`define OFS_TINT_SENSE 8'h62
`define OFS_TINT_THR 8'h63
`define OFS_TINT_BAND 8'h64
`define OFS_CURVE_FIRST 8'h70
`define OFS_CURVE_LAST 8'h97
`define CFG_BASE 8'h20
`define CFG_WORDS 69
`define CURVE_POINTS 20
`define LOCKOUT_MASK 16'h000f
`define TINT_FLAG_MASK 16'h00c3
`define TINT_FAULT_BIT 7
`define TINT_EXTREME_BIT 6
`define TINT_OUT2_BIT 1
`define TINT_OUT1_BIT 0
`define POINT_FREE 16'h8000
`define EXC_NONE 8'h00
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03
`define EXC_DENIED 8'h08
`define RST_STATION 16'h0001
`define RST_BAUD 16'h0003
`define RST_PERMIT 16'h0001
`define RST_GLOW 16'h0008
`endif

/* File: meter_config_pkg.sv */
// types shared by the meter settings bank and its neighbours
// constants live in meter_config_regs.svh
package meter_config_pkg;
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [15:0] data;
    } req_t;
    typedef struct packed {
        logic valid;
        logic [7:0] exc;
        logic [15:0] data;
        logic [7:0] station;
    } reply_extra_wait_t;
    typedef enum logic [2:0] {
        MODE_INACTIVE, MODE_FORCE_ON, MODE_FORCE_OFF,
        MODE_IN_BAND, MODE_OUT_BAND, MODE_BUS
    } out_mode_t;
    typedef enum logic [1:0] {FAULT_KEEP, FAULT_ON, FAULT_OFF} fault_t;
    typedef struct packed {
        logic [7:0] station;
        logic [2:0] baud;
        logic permit;
        logic [3:0] lockout;
        logic [7:0] reply_wait_chars;
        logic gap_check_en;
        logic [6:0] gap_s;
        logic [3:0] glow;
        logic tint_red;
        logic ramp_edit;
        logic [1:0][2:0] out_mode;
        logic [1:0] out_unit_min;
        logic [1:0][1:0] out_fault;
        logic capture_drops;
        logic [7:0] show_s;
        logic display_freeze;
        logic [1:0] out_freeze;
        logic tint_on_fault;
        logic tint_on_extreme;
        logic [1:0] tint_on_output;
        logic tint_clear;
        logic falling_sense;
    } settings_t;
endpackage : meter_config_pkg

/* File: meter_config_register_map.sv */
// holding-register bank of the panel meter, served to the serial frame decoder
// assumes the decoder hands one register access per request and sends the reply
//
// How it works
// - bus writes refused while permit is zero
// - bus may deny writes, only menu or reset re-allows
// - lockout register holds four on/off flags
// - reply wait codes 0..5 select extra delay
// - frame gap 0 disables, 1..99 seconds
// - glow 1 lowest to 8 highest
// - base tint 0 green, 1 red
// - edit style 0 per place, 1 ramp
// - output mode codes 0 to 5
// - output waits 0..999 in tenths
// - time unit 0 seconds, 1 minutes
// - fault reaction keep, on or off
// - capture type 0 peaks, 1 drops
// - extreme show limit 0..199 seconds
// - freeze settings 0 live, 1 captured
// - tint flags in bits 7,6,1,0
// - tint clear enable and change sense
// - twenty X/Y curve pairs with ranges
// - X equal 8000h marks point free
// - point defined after both coordinates written
// - station address reply uses old address
// - baud change applies to its reply
// - denied write answers exception 08h
// - out of range value answers 03h
// - unmapped register answers 02h
`timescale 1ns/10ps
`include "meter_config_regs.svh"

module meter_config_register_map (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire meter_config_pkg::req_t req_i,
    input wire logic menu_permit_set_i,
    output meter_config_pkg::reply_extra_wait_t reply_extra_wait_o,
    output meter_config_pkg::settings_t settings_o,
    output logic [`CURVE_POINTS-1:0] point_defined_o
);

    typedef struct packed {
        logic [`CFG_WORDS-1:0][15:0] cfg;
        logic [`CURVE_POINTS-1:0][15:0] cx;
        logic [`CURVE_POINTS-1:0][15:0] cy;
        logic [`CURVE_POINTS-1:0] xw;
        logic [`CURVE_POINTS-1:0] yw;
        meter_config_pkg::reply_extra_wait_t reply_extra_wait;
    } state_t;

    state_t st;
    state_t next_st;

    ////////////////////////////////////////////////////////////////////////
    // decoding

    function automatic logic in_cfg(input logic [15:0] a);
        logic [7:0] b;
        b = a[7:0];
        if (a[15:8] != 8'h00) begin
            in_cfg = 1'b0;
        end else if (b == `OFS_STATION) begin
            in_cfg = 1'b1;
        end else if (b >= `OFS_BAUD && b <= `OFS_REPLY_WAIT) begin
            in_cfg = 1'b1;
        end else if (b == `OFS_GAP) begin
            in_cfg = 1'b1;
        end else if (b >= `OFS_GLOW && b <= `OFS_O2_THR2) begin
            in_cfg = 1'b1;
        end else if (b >= `OFS_CAPTURE && b <= `OFS_O2_FRZ) begin
            in_cfg = 1'b1;
        end else if (b >= `OFS_TINT_FLAGS && b <= `OFS_TINT_BAND) begin
            in_cfg = 1'b1;
        end else begin
            in_cfg = 1'b0;
        end
    endfunction : in_cfg

    function automatic logic in_curve(input logic [15:0] a);
        in_curve = a[15:8] == 8'h00 && a[7:0] >= `OFS_CURVE_FIRST
            && a[7:0] <= `OFS_CURVE_LAST;
    endfunction : in_curve

    function automatic logic span(input logic [15:0] d,
                                  input int lo, input int hi);
        int v;
        v = int'($signed(d));
        span = v >= lo && v <= hi;
    endfunction : span

    function automatic logic value_ok(input logic [15:0] a,
                                      input logic [15:0] d);
        logic [7:0] b;
        b = a[7:0];
        if (b == `OFS_STATION) begin
            value_ok = span(d, 0, 199);
        end else if (b == `OFS_BAUD) begin
            value_ok = span(d, 0, 7);
        end else if (b == `OFS_LOCKOUT) begin
            value_ok = (d & ~`LOCKOUT_MASK) == 16'h0000;
        end else if (b == `OFS_REPLY_WAIT) begin
            value_ok = span(d, 0, 5);
        end else if (b == `OFS_GAP) begin
            value_ok = span(d, 0, 99);
        end else if (b == `OFS_GLOW) begin
            value_ok = span(d, 1, 8);
        end else if (b == `OFS_O1_THR || b == `OFS_O1_THR2 || b == `OFS_O2_THR
                     || b == `OFS_O2_THR2 || b == `OFS_TINT_THR) begin
            value_ok = span(d, -999, 9999);
        end else if (b == `OFS_O1_BAND || b == `OFS_O2_BAND
                     || b == `OFS_TINT_BAND) begin
            value_ok = span(d, -999, 999);
        end else if (b == `OFS_O1_MODE || b == `OFS_O2_MODE) begin
            value_ok = span(d, 0, 5);
        end else if (b == `OFS_O1_ON || b == `OFS_O1_OFF
                     || b == `OFS_O2_ON || b == `OFS_O2_OFF) begin
            value_ok = span(d, 0, 999);
        end else if (b == `OFS_O1_FAULT || b == `OFS_O2_FAULT) begin
            value_ok = span(d, 0, 2);
        end else if (b == `OFS_MIN_EXC) begin
            value_ok = span(d, 0, 9999);
        end else if (b == `OFS_SHOW) begin
            value_ok = span(d, 0, 199);
        end else if (b == `OFS_TINT_FLAGS) begin
            value_ok = (d & ~`TINT_FLAG_MASK) == 16'h0000;
        end else if (in_curve(a) && !b[0]) begin
            // the free marker is accepted so a point can be released
            value_ok = span(d, -999, 1999) || d == `POINT_FREE;
        end else if (in_curve(a)) begin
            value_ok = span(d, -999, 9999);
        end else begin
            // the remaining settings are all two-way switches
            value_ok = span(d, 0, 1);
        end
    endfunction : value_ok

    function automatic logic [7:0] wait_chars(input logic [15:0] c);
        if (c == 16'h0001) begin
            wait_chars = 8'h0a;
        end else if (c == 16'h0002) begin
            wait_chars = 8'h14;
        end else if (c == 16'h0003) begin
            wait_chars = 8'h32;
        end else if (c == 16'h0004) begin
            wait_chars = 8'h64;
        end else if (c == 16'h0005) begin
            wait_chars = 8'hc8;
        end else begin
            wait_chars = 8'h00;
        end
    endfunction : wait_chars

    function automatic logic [15:0] cfg_rd(input state_t s, input logic [7:0] b);
        logic [7:0] i;
        i = b - `CFG_BASE;
        cfg_rd = s.cfg[i[6:0]];
    endfunction : cfg_rd

    ////////////////////////////////////////////////////////////////////////
    // next state

    logic [7:0] a8;
    logic [7:0] ci;
    logic [7:0] pi;
    logic permit;

    always_comb begin
        next_st = st;
        a8 = req_i.addr[7:0];
        ci = a8 - `CFG_BASE;
        pi = (a8 - `OFS_CURVE_FIRST) >> 1;
        permit = st.cfg[`OFS_PERMIT - `CFG_BASE][0];
        next_st.reply_extra_wait = '0;
        // reply carries the address in force before this request
        next_st.reply_extra_wait.station = st.cfg[`OFS_STATION - `CFG_BASE][7:0];
        if (req_i.valid) begin
            next_st.reply_extra_wait.valid = 1'b1;
            if (!in_cfg(req_i.addr) && !in_curve(req_i.addr)) begin
                next_st.reply_extra_wait.exc = `EXC_ADDR;
            end else if (!req_i.write) begin
                if (in_curve(req_i.addr) && !a8[0]) begin
                    next_st.reply_extra_wait.data = st.cx[pi[4:0]];
                end else if (in_curve(req_i.addr)) begin
                    next_st.reply_extra_wait.data = st.cy[pi[4:0]];
                end else begin
                    next_st.reply_extra_wait.data = cfg_rd(st, a8);
                end
            end else if (!permit) begin
                // covers a bus write of 1 to the permit: only the menu or a reset lifts it
                next_st.reply_extra_wait.exc = `EXC_DENIED;
            end else if (!value_ok(req_i.addr, req_i.data)) begin
                next_st.reply_extra_wait.exc = `EXC_VALUE;
            end else begin
                next_st.reply_extra_wait.data = req_i.data;
                if (in_curve(req_i.addr) && !a8[0]) begin
                    next_st.cx[pi[4:0]] = req_i.data;
                    next_st.xw[pi[4:0]] = req_i.data != `POINT_FREE;
                end else if (in_curve(req_i.addr)) begin
                    next_st.cy[pi[4:0]] = req_i.data;
                    next_st.yw[pi[4:0]] = 1'b1;
                end else begin
                    // baud takes effect with this reply's own frame
                    next_st.cfg[ci[6:0]] = req_i.data;
                end
            end
        end
        // the menu or a reset is the only way back to allowed; the menu wins over a bus write
        if (menu_permit_set_i) begin
            next_st.cfg[`OFS_PERMIT - `CFG_BASE] = `RST_PERMIT;
        end
        if (!rst_n_i) begin
            next_st = '0;
            next_st.cfg[`OFS_STATION - `CFG_BASE] = `RST_STATION;
            next_st.cfg[`OFS_BAUD - `CFG_BASE] = `RST_BAUD;
            next_st.cfg[`OFS_PERMIT - `CFG_BASE] = `RST_PERMIT;
            next_st.cfg[`OFS_GLOW - `CFG_BASE] = `RST_GLOW;
            for (int k = 0; k < `CURVE_POINTS; k++) begin
                next_st.cx[k] = `POINT_FREE;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign reply_extra_wait_o = st.reply_extra_wait;

    genvar g;
    generate
        for (g = 0; g < `CURVE_POINTS; g++) begin : g_point
            assign point_defined_o[g] = st.xw[g] && st.yw[g]
                && st.cx[g] != `POINT_FREE;
        end
    endgenerate

    always_comb begin
        settings_o = '0;
        settings_o.station = st.cfg[`OFS_STATION - `CFG_BASE][7:0];
        settings_o.baud = st.cfg[`OFS_BAUD - `CFG_BASE][2:0];
        settings_o.permit = st.cfg[`OFS_PERMIT - `CFG_BASE][0];
        settings_o.lockout = st.cfg[`OFS_LOCKOUT - `CFG_BASE][3:0];
        settings_o.reply_wait_chars = wait_chars(st.cfg[`OFS_REPLY_WAIT - `CFG_BASE]);
        settings_o.gap_check_en = st.cfg[`OFS_GAP - `CFG_BASE] != 16'h0000;
        settings_o.gap_s = st.cfg[`OFS_GAP - `CFG_BASE][6:0];
        settings_o.glow = st.cfg[`OFS_GLOW - `CFG_BASE][3:0];
        settings_o.tint_red = st.cfg[`OFS_TINT - `CFG_BASE][0];
        settings_o.ramp_edit = st.cfg[`OFS_EDIT - `CFG_BASE][0];
        settings_o.out_mode[0] = st.cfg[`OFS_O1_MODE - `CFG_BASE][2:0];
        settings_o.out_mode[1] = st.cfg[`OFS_O2_MODE - `CFG_BASE][2:0];
        settings_o.out_unit_min[0] = st.cfg[`OFS_O1_UNIT - `CFG_BASE][0];
        settings_o.out_unit_min[1] = st.cfg[`OFS_O2_UNIT - `CFG_BASE][0];
        settings_o.out_fault[0] = st.cfg[`OFS_O1_FAULT - `CFG_BASE][1:0];
        settings_o.out_fault[1] = st.cfg[`OFS_O2_FAULT - `CFG_BASE][1:0];
        settings_o.capture_drops = st.cfg[`OFS_CAPTURE - `CFG_BASE][0];
        settings_o.show_s = st.cfg[`OFS_SHOW - `CFG_BASE][7:0];
        settings_o.display_freeze = st.cfg[`OFS_DISP_FRZ - `CFG_BASE][0];
        settings_o.out_freeze[0] = st.cfg[`OFS_O1_FRZ - `CFG_BASE][0];
        settings_o.out_freeze[1] = st.cfg[`OFS_O2_FRZ - `CFG_BASE][0];
        settings_o.tint_on_fault = st.cfg[`OFS_TINT_FLAGS - `CFG_BASE][`TINT_FAULT_BIT];
        settings_o.tint_on_extreme = st.cfg[`OFS_TINT_FLAGS - `CFG_BASE][`TINT_EXTREME_BIT];
        settings_o.tint_on_output[1] = st.cfg[`OFS_TINT_FLAGS - `CFG_BASE][`TINT_OUT2_BIT];
        settings_o.tint_on_output[0] = st.cfg[`OFS_TINT_FLAGS - `CFG_BASE][`TINT_OUT1_BIT];
        settings_o.tint_clear = st.cfg[`OFS_TINT_CLR - `CFG_BASE][0];
        settings_o.falling_sense = st.cfg[`OFS_TINT_SENSE - `CFG_BASE][0];
    end

endmodule : meter_config_register_map

/* File: meter_config_register_map_chk.sv */
// port assertions for the meter settings bank
// assumes binding onto meter_config_register_map, one clock domain
`timescale 1ns/10ps
`include "meter_config_regs.svh"
module meter_config_register_map_chk (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire meter_config_pkg::req_t req_i,
    input wire logic menu_permit_set_i,
    input wire meter_config_pkg::reply_extra_wait_t reply_extra_wait_o,
    input wire meter_config_pkg::settings_t settings_o,
    input wire logic [`CURVE_POINTS-1:0] point_defined_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    AST_ANSWER: assert property (reply_extra_wait_o.valid == $past(req_i.valid))
        else $error("answer not one cycle after request");
    AST_UNMAPPED: assert property (req_i.valid && req_i.addr[15:8] != 8'h00
        |=> reply_extra_wait_o.exc == `EXC_ADDR) else $error("high address not refused");
    AST_DENIED: assert property (req_i.valid && req_i.write
        && req_i.addr == {8'h00, `OFS_TINT} && !settings_o.permit && !menu_permit_set_i
        |=> reply_extra_wait_o.exc == `EXC_DENIED) else $error("write passed while denied");
    AST_NO_REALLOW: assert property (!settings_o.permit && !menu_permit_set_i
        |=> !settings_o.permit) else $error("permit re-allowed without menu");
    AST_MENU: assert property (menu_permit_set_i |=> settings_o.permit)
        else $error("menu did not re-allow writes");
    AST_OLD_STATION: assert property (req_i.valid
        |=> reply_extra_wait_o.station == $past(settings_o.station)) else $error("reply station moved");
    AST_GLOW_RANGE: assert property (req_i.valid && req_i.write && settings_o.permit
        && req_i.addr == {8'h00, `OFS_GLOW} && req_i.data == 16'h0009
        |=> reply_extra_wait_o.exc == `EXC_VALUE ##1 settings_o.glow != 4'h9) else $error("glow 9 taken");
    AST_GLOW_HELD: assert property (settings_o.glow >= 4'h1 && settings_o.glow <= 4'h8)
        else $error("glow out of range");
    AST_POINT_FREE: assert property (req_i.valid && req_i.write && settings_o.permit
        && req_i.addr == {8'h00, `OFS_CURVE_FIRST} && req_i.data == `POINT_FREE
        |=> !point_defined_o[0]) else $error("freed point still defined");
    AST_EXC_DATA: assert property (reply_extra_wait_o.valid && reply_extra_wait_o.exc != `EXC_NONE
        |-> reply_extra_wait_o.data == 16'h0000) else $error("refusal carries data");
endmodule : meter_config_register_map_chk

bind meter_config_register_map meter_config_register_map_chk chk (.clk_sys_i, .rst_n_i,
    .req_i, .menu_permit_set_i, .reply_extra_wait_o, .settings_o, .point_defined_o);

/* File: serial_master_model.sv */
// request side standing in for the remote serial bus master
// assumes the answer shows on reply_extra_wait_i just after the taking edge, registered on that same edge
`timescale 1ns/10ps
module serial_master_model (
    input wire logic clk_sys_i,
    input wire meter_config_pkg::reply_extra_wait_t reply_extra_wait_i,
    output meter_config_pkg::req_t req_o
);
    initial begin
        req_o = '0;
    end
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
        output meter_config_pkg::reply_extra_wait_t rsp, output logic got);
        @(posedge clk_sys_i);
        req_o <= '{valid: 1'b1, write: wr, addr: a, data: d};
        @(posedge clk_sys_i);
        // released fields inverted so a stale value cannot pass
        req_o <= '{valid: 1'b0, write: ~wr, addr: ~a, data: ~d};
        got = 1'b0;
        for (int i = 0; i < 4 && !got; i++) begin
            #1;
            got = reply_extra_wait_i.valid;
            if (!got) @(posedge clk_sys_i);
        end
        rsp = reply_extra_wait_i;
    endtask : access
endmodule : serial_master_model

/* File: meter_config_register_map_tb_top.sv */
// self-checking bench for the meter settings bank
// assumes the master model answers within four cycles
`timescale 1ns/10ps
`include "meter_config_regs.svh"
module meter_config_register_map_tb_top;
    logic clk_sys_i;
    logic rst_n_i;
    logic menu_permit_set_i;
    meter_config_pkg::req_t req;
    meter_config_pkg::reply_extra_wait_t reply_extra_wait;
    meter_config_pkg::reply_extra_wait_t rsp;
    meter_config_pkg::settings_t st;
    logic [`CURVE_POINTS-1:0] pdef;
    logic got;
    int n_errors;
    int samples_checked;
    meter_config_register_map DUT (.clk_sys_i, .rst_n_i, .req_i(req), .menu_permit_set_i,
        .reply_extra_wait_o(reply_extra_wait), .settings_o(st), .point_defined_o(pdef));
    serial_master_model master (.clk_sys_i, .reply_extra_wait_i(reply_extra_wait), .req_o(req));
    ////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic tally_and_finish();
        $display("compared %0d, wrong %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk_val
    task automatic chk_exc(input logic [7:0] g, input logic [7:0] e);
        chk_val({8'h00, g}, {8'h00, e});
    endtask : chk_exc
    task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d,
        input logic [7:0] e);
        master.access(wr, a, d, rsp, got);
        if (!got) begin
            n_errors++;
            tally_and_finish();
        end else begin
            chk_exc(rsp.exc, e);
            // refusals echo nothing
            if (wr) chk_val(rsp.data, (e == `EXC_NONE) ? d : 16'h0000);
        end
    endtask : acc
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        acc(1'b0, a, 16'h0000, `EXC_NONE);
        chk_val(rsp.data, e);
    endtask : rd
    task automatic sc_reset();
        logic [15:0] hole [9] = '{16'h0021, 16'h0026, 16'h0028, 16'h002c, 16'h0040,
            16'h0056, 16'h0065, 16'h0098, 16'h0123};
        rd({8'h00, `OFS_GLOW}, `RST_GLOW);
        rd({8'h00, `OFS_CURVE_FIRST}, `POINT_FREE);
        foreach (hole[i]) acc(i[0], hole[i], 16'h0001, `EXC_ADDR);
    endtask : sc_reset
    task automatic sc_ranges();
        logic [15:0] a [10] = '{16'h0024, 16'h0025, 16'h0027, 16'h002d, 16'h0032, 16'h0033,
            16'h0036, 16'h0052, 16'h0060, 16'h0031};
        logic [15:0] ok [10] = '{16'h000f, 16'h0005, 16'h0063, 16'h0001, 16'h0005, 16'h03e7,
            16'h0002, 16'h00c7, 16'h00c3, 16'hfc19};
        logic [15:0] bad [10] = '{16'h0010, 16'h0006, 16'h0064, 16'h0009, 16'h0006, 16'h03e8,
            16'h0003, 16'h00c8, 16'h0004, 16'h03e8};
        foreach (a[i]) begin
            acc(1'b1, a[i], ok[i], `EXC_NONE);
            acc(1'b1, a[i], bad[i], `EXC_VALUE);
            rd(a[i], ok[i]);
        end
        chk_val({12'h000, st.lockout}, 16'h000f);
        chk_val({8'h00, st.gap_check_en, st.gap_s}, 16'h00e3);
        chk_val({8'h00, st.show_s}, 16'h00c7);
        chk_val({13'h0000, st.out_mode[0]}, 16'h0005);
        chk_val({12'h000, st.tint_on_fault, st.tint_on_extreme, st.tint_on_output}, 16'h000f);
    endtask : sc_ranges
    task automatic sc_codes();
        logic [7:0] chars [6] = '{8'h00, 8'h0a, 8'h14, 8'h32, 8'h64, 8'hc8};
        logic [15:0] flag [10] = '{16'h002e, 16'h002f, 16'h0035, 16'h003d, 16'h0050, 16'h0053,
            16'h0054, 16'h0055, 16'h0061, 16'h0062};
        for (int k = 0; k < 6; k++) begin
            acc(1'b1, {8'h00, `OFS_REPLY_WAIT}, 16'(k), `EXC_NONE);
            acc(1'b1, {8'h00, `OFS_O2_MODE}, 16'(k), `EXC_NONE);
            acc(1'b1, {8'h00, `OFS_O1_FAULT}, 16'(k % 3), `EXC_NONE);
            chk_val({8'h00, st.reply_wait_chars}, {8'h00, chars[k]});
            chk_val({13'h0000, st.out_mode[1]}, 16'(k));
            chk_val({14'h0000, st.out_fault[0]}, 16'(k % 3));
        end
        acc(1'b1, {8'h00, `OFS_O2_FAULT}, 16'h0002, `EXC_NONE);
        chk_val({14'h0000, st.out_fault[1]}, 16'h0002);
        foreach (flag[i]) acc(1'b1, flag[i], 16'h0001, `EXC_NONE);
        acc(1'b1, {8'h00, `OFS_TINT}, 16'h0002, `EXC_VALUE);
        chk_val({6'h00, st.tint_red, st.ramp_edit, st.out_unit_min, st.capture_drops,
            st.display_freeze, st.out_freeze, st.tint_clear, st.falling_sense}, 16'h03ff);
    endtask : sc_codes
    task automatic sc_curve();
        acc(1'b1, 16'h0070, 16'h07cf, `EXC_NONE);
        chk_val({15'h0000, pdef[0]}, 16'h0000);
        acc(1'b1, 16'h0071, 16'h270f, `EXC_NONE);
        chk_val({15'h0000, pdef[0]}, 16'h0001);
        acc(1'b1, 16'h0096, 16'h07d0, `EXC_VALUE);
        acc(1'b1, 16'h0097, 16'hfc18, `EXC_VALUE);
        acc(1'b1, 16'h0070, `POINT_FREE, `EXC_NONE);
        chk_val({15'h0000, pdef[0]}, 16'h0000);
        acc(1'b1, 16'h0070, 16'hfc19, `EXC_NONE);
        chk_val({15'h0000, pdef[0]}, 16'h0001);
        acc(1'b1, 16'h0096, 16'h07cf, `EXC_NONE);
        acc(1'b1, 16'h0097, 16'hfc19, `EXC_NONE);
        chk_val({15'h0000, pdef[19]}, 16'h0001);
        rd(16'h0097, 16'hfc19);
    endtask : sc_curve
    task automatic sc_link();
        acc(1'b1, {8'h00, `OFS_STATION}, 16'h0005, `EXC_NONE);
        chk_val({8'h00, rsp.station}, `RST_STATION);
        rd({8'h00, `OFS_STATION}, 16'h0005);
        chk_val({8'h00, rsp.station}, 16'h0005);
        acc(1'b1, {8'h00, `OFS_BAUD}, 16'h0007, `EXC_NONE);
        chk_val({13'h0000, st.baud}, 16'h0007);
    endtask : sc_link
    task automatic sc_permit();
        acc(1'b1, {8'h00, `OFS_PERMIT}, 16'h0000, `EXC_NONE);
        acc(1'b1, {8'h00, `OFS_TINT}, 16'h0000, `EXC_DENIED);
        acc(1'b1, {8'h00, `OFS_PERMIT}, 16'h0001, `EXC_DENIED);
        acc(1'b1, 16'h0026, 16'h0000, `EXC_ADDR);
        acc(1'b1, {8'h00, `OFS_GLOW}, 16'h0000, `EXC_DENIED);
        rd({8'h00, `OFS_TINT}, 16'h0001);
        @(posedge clk_sys_i);
        menu_permit_set_i <= 1'b1;
        @(posedge clk_sys_i);
        menu_permit_set_i <= 1'b0;
        rd({8'h00, `OFS_PERMIT}, 16'h0001);
        acc(1'b1, {8'h00, `OFS_TINT}, 16'h0000, `EXC_NONE);
    endtask : sc_permit
    initial begin
        rst_n_i = 1'b0;
        menu_permit_set_i = 1'b0;
        n_errors = 0;
        samples_checked = 0;
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        sc_reset();
        sc_ranges();
        sc_codes();
        sc_curve();
        sc_link();
        sc_permit();
        tally_and_finish();
    end
endmodule : meter_config_register_map_tb_top
